//--- rtl/modem_buffer_port_config_regs.v
/*
 register bank for the modem buffer manager port setup, the
 acknowledge-detect interrupt and the outgoing header start address.
 assumes a single-cycle special-function register port from the
 embedded processor, synchronous to core_clk, and a one-cycle
 acknowledge-detected pulse from the physical layer.
*/
`timescale 1ns/1ps
`default_nettype none
`include "modem_buffer_port_consts.vh"

// Behaviour
// - every reset loads buffer_port_control with 4070h.
// - zero burst length field moves one byte or word per access.
// - nonzero burst length enables bursts of field value plus one units.
// - bit 4 and bit 9 select word (set) or byte (clear) per port.
// - reserved bits read zero, except control bit 14, which reads one from reset until a control write.
// - every reset clears ack_interrupt_control to 0000h.
// - acknowledge symbol from the physical layer sets flag bit 0.
// - enable bit 8 lets an acknowledge detection raise the request.
// - every reset clears out_header_start_address to 0000h.
// - bits 0 to 11 hold the outgoing header buffer start location.
// - logical header address is translated to a physical buffer location.
module modem_buffer_port_config_regs #(
  parameter [`HDR_ADDR_W-1:0] PHYS_BASE = 12'h000,
  parameter PORTS = 2
) (
  // clock and reset
  input wire core_clk,
  input wire reset,
  // special-function register port
  input wire [3:0] sfr_module,
  input wire [7:0] sfr_addr,
  input wire sfr_wr,
  input wire sfr_rd,
  input wire [15:0] sfr_wdata,
  output reg [15:0] sfr_rdata,
  // physical layer event
  input wire ack_symbol_seen,
  // arbiter port setup
  output reg [`BURST_LEN_W-1:0] port0_burst_length,
  output reg port0_word_select,
  output reg port0_burst_enable,
  output reg [`BURST_LEN_W:0] port0_burst_units,
  output reg [`BURST_LEN_W-1:0] port1_burst_length,
  output reg port1_word_select,
  output reg port1_burst_enable,
  output reg [`BURST_LEN_W:0] port1_burst_units,
  // interrupt request
  output reg ack_seen_irq,
  // outgoing header location
  output reg [`HDR_ADDR_W-1:0] out_header_byte_addr,
  output reg [`HDR_ADDR_W-1:0] out_header_phys_addr
);

  reg [15:0] ctrl_q;
  reg [15:0] ctrl_d;
  reg ack_seen_flag_q;
  reg ack_seen_flag_d;
  reg ack_seen_irq_enable_q;
  reg ack_seen_irq_enable_d;
  reg [`HDR_ADDR_W-1:0] hdr_q;
  reg [`HDR_ADDR_W-1:0] hdr_d;
  reg [15:0] rdata_d;

  // reset images, all derived from the reset words of the registers
  localparam [15:0] CTRL_RST = `RST_BUFFER_PORT_CONTROL;
  localparam [15:0] IRQ_RST = `RST_ACK_INTERRUPT_CONTROL;
  localparam [15:0] HDR_RST_WORD = `RST_OUT_HEADER_START_ADDRESS;
  localparam [`BURST_LEN_W-1:0] P0_LEN_RST =
    CTRL_RST[`PORT0_BURST_LSB +: `BURST_LEN_W];
  localparam [`BURST_LEN_W-1:0] P1_LEN_RST =
    CTRL_RST[`PORT1_BURST_LSB +: `BURST_LEN_W];
  localparam [0:0] P0_WORD_RST =
    CTRL_RST[`PORT0_BURST_LSB + `WORD_SELECT_OFS];
  localparam [0:0] P1_WORD_RST =
    CTRL_RST[`PORT1_BURST_LSB + `WORD_SELECT_OFS];
  localparam [0:0] P0_BURST_RST = |P0_LEN_RST;
  localparam [0:0] P1_BURST_RST = |P1_LEN_RST;
  localparam [`BURST_LEN_W:0] P0_UNITS_RST = {1'b0, P0_LEN_RST} + 5'h01;
  localparam [`BURST_LEN_W:0] P1_UNITS_RST = {1'b0, P1_LEN_RST} + 5'h01;
  localparam [0:0] FLAG_RST = IRQ_RST[`ACK_SEEN_FLAG_BIT];
  localparam [0:0] ENABLE_RST = IRQ_RST[`ACK_SEEN_IRQ_ENABLE_BIT];
  localparam [`HDR_ADDR_W-1:0] HDR_RST = HDR_RST_WORD[`HDR_ADDR_W-1:0];
  localparam [`HDR_ADDR_W:0] PHYS_RST_SUM =
    {1'b0, HDR_RST} + {1'b0, PHYS_BASE};
  localparam [`HDR_ADDR_W-1:0] PHYS_RST = PHYS_RST_SUM[`HDR_ADDR_W-1:0];

  wire [`HDR_ADDR_W:0] phys_sum;
  wire irq_d;

  // carry dropped on purpose: the buffer window wraps at 4 kB
  assign phys_sum = {1'b0, hdr_d} + {1'b0, PHYS_BASE};
  assign irq_d = ack_seen_flag_d & ack_seen_irq_enable_d;

  wire sel;
  wire wr_ctrl;
  wire wr_irq;
  wire wr_hdr;
  wire [`BURST_LEN_W-1:0] len_d [0:PORTS-1];
  wire word_d [0:PORTS-1];
  wire burst_d [0:PORTS-1];
  wire [`BURST_LEN_W:0] units_d [0:PORTS-1];

  assign sel = (sfr_module == `SFR_MODULE_ID);
  assign wr_ctrl = sel & sfr_wr & (sfr_addr == `OFF_BUFFER_PORT_CONTROL);
  assign wr_irq = sel & sfr_wr & (sfr_addr == `OFF_ACK_INTERRUPT_CONTROL);
  assign wr_hdr = sel & sfr_wr & (sfr_addr == `OFF_OUT_HEADER_START_ADDRESS);

  // next register values
  always @* begin
    ctrl_d = ctrl_q;
    if (wr_ctrl) begin
      ctrl_d = sfr_wdata & `MASK_BUFFER_PORT_CONTROL;
    end
    ack_seen_irq_enable_d = ack_seen_irq_enable_q;
    if (wr_irq) begin
      ack_seen_irq_enable_d = sfr_wdata[`ACK_SEEN_IRQ_ENABLE_BIT];
    end
    ack_seen_flag_d = ack_seen_flag_q;
    // only a zero write clears; a one written by firmware is ignored
    if (wr_irq && !sfr_wdata[`ACK_SEEN_FLAG_BIT]) begin
      ack_seen_flag_d = 1'b0;
    end
    // an acknowledge in the clearing cycle is kept, set beats clear
    if (ack_symbol_seen) begin
      ack_seen_flag_d = 1'b1;
    end
    hdr_d = hdr_q;
    if (wr_hdr) begin
      hdr_d = sfr_wdata[`HDR_ADDR_W-1:0];
    end
  end

  // per-port field decode, same layout shifted for each port
  genvar g;
  generate
    for (g = 0; g < PORTS; g = g + 1) begin : port_decode
      localparam LSB = g * `PORT1_BURST_LSB;
      assign len_d[g] = ctrl_d[LSB +: `BURST_LEN_W];
      assign word_d[g] = ctrl_d[LSB + `WORD_SELECT_OFS];
      assign burst_d[g] = |len_d[g];
      assign units_d[g] = {1'b0, len_d[g]} + 5'h01;
    end
  endgenerate

  // read mux, reserved bits already held at zero except control bit 14 from reset
  always @* begin
    rdata_d = 16'h0000;
    if (sel && sfr_rd) begin
      case (sfr_addr)
        `OFF_BUFFER_PORT_CONTROL: begin
          rdata_d = ctrl_q;
        end
        `OFF_ACK_INTERRUPT_CONTROL: begin
          rdata_d[`ACK_SEEN_FLAG_BIT] = ack_seen_flag_q;
          rdata_d[`ACK_SEEN_IRQ_ENABLE_BIT] = ack_seen_irq_enable_q;
        end
        `OFF_OUT_HEADER_START_ADDRESS: begin
          rdata_d[`HDR_ADDR_W-1:0] = hdr_q;
        end
        default: begin
          rdata_d = 16'h0000;
        end
      endcase
    end
  end

  // storage registers
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ctrl_q <= CTRL_RST;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ack_seen_flag_q <= FLAG_RST;
    end else begin
      ack_seen_flag_q <= ack_seen_flag_d;
    end
  end

  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ack_seen_irq_enable_q <= ENABLE_RST;
    end else begin
      ack_seen_irq_enable_q <= ack_seen_irq_enable_d;
    end
  end

  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      hdr_q <= HDR_RST;
    end else begin
      hdr_q <= hdr_d;
    end
  end

  // read data stands one cycle, then drops back to zero
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      sfr_rdata <= 16'h0000;
    end else begin
      sfr_rdata <= rdata_d;
    end
  end

  // outputs registered from next values so they track storage exactly
  // port 0 setup
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      port0_burst_length <= P0_LEN_RST;
    end else begin
      port0_burst_length <= len_d[0];
    end
  end

  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      port0_word_select <= P0_WORD_RST;
    end else begin
      port0_word_select <= word_d[0];
    end
  end

  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      port0_burst_enable <= P0_BURST_RST;
    end else begin
      port0_burst_enable <= burst_d[0];
    end
  end

  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      port0_burst_units <= P0_UNITS_RST;
    end else begin
      port0_burst_units <= units_d[0];
    end
  end

  // port 1 setup
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      port1_burst_length <= P1_LEN_RST;
    end else begin
      port1_burst_length <= len_d[1];
    end
  end

  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      port1_word_select <= P1_WORD_RST;
    end else begin
      port1_word_select <= word_d[1];
    end
  end

  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      port1_burst_enable <= P1_BURST_RST;
    end else begin
      port1_burst_enable <= burst_d[1];
    end
  end

  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      port1_burst_units <= P1_UNITS_RST;
    end else begin
      port1_burst_units <= units_d[1];
    end
  end

  // request is a level; it follows the flag while enable bit 8 is set
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ack_seen_irq <= 1'b0;
    end else begin
      ack_seen_irq <= irq_d;
    end
  end

  // header location, logical and translated
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      out_header_byte_addr <= HDR_RST;
    end else begin
      out_header_byte_addr <= hdr_d;
    end
  end

  // simple base offset mapping; no protection against a wrapped header
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      out_header_phys_addr <= PHYS_RST;
    end else begin
      out_header_phys_addr <= phys_sum[`HDR_ADDR_W-1:0];
    end
  end

endmodule // modem_buffer_port_config_regs
`default_nettype wire

//--- rtl/modem_buffer_port_consts.vh
/*
 constants for the modem buffer port configuration registers:
 register offsets, field positions, reset values and read masks.
 assumes inclusion by bare name from the register bank module.
*/
`ifndef MODEM_BUFFER_PORT_CONSTS_VH
`define MODEM_BUFFER_PORT_CONSTS_VH

// special-function register module and offsets
`define SFR_MODULE_ID 4'h2
`define OFF_BUFFER_PORT_CONTROL 8'h0c
`define OFF_ACK_INTERRUPT_CONTROL 8'h0d
`define OFF_OUT_HEADER_START_ADDRESS 8'h0e

// reset values
`define RST_BUFFER_PORT_CONTROL 16'h4070
`define RST_ACK_INTERRUPT_CONTROL 16'h0000
`define RST_OUT_HEADER_START_ADDRESS 16'h0000

// implemented-bit masks, reserved bits read zero except control bit 14 from reset
`define MASK_BUFFER_PORT_CONTROL 16'h03ff
`define MASK_ACK_INTERRUPT_CONTROL 16'h0101
`define MASK_OUT_HEADER_START_ADDRESS 16'h0fff

// buffer_port_control fields
`define PORT0_BURST_LSB 0
`define PORT1_BURST_LSB 5
`define BURST_LEN_W 4
`define WORD_SELECT_OFS 4

// ack_interrupt_control fields
`define ACK_SEEN_FLAG_BIT 0
`define ACK_SEEN_IRQ_ENABLE_BIT 8

// header address width
`define HDR_ADDR_W 12

`endif

//--- testbench/port_regs_monitor.sv
/*
 port checks for the buffer port register bank.
 assumes bind onto the register bank, one clock, reset high.
*/
`timescale 1ns/1ps
`default_nettype none
module port_regs_monitor #(
  parameter logic [11:0] PHYS_BASE = 12'h000
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // register port
  input wire logic [3:0] sfr_module,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [15:0] sfr_wdata,
  input wire logic [15:0] sfr_rdata,
  // event and setup
  input wire logic ack_symbol_seen,
  input wire logic [3:0] port0_burst_length,
  input wire logic port0_word_select,
  input wire logic port0_burst_enable,
  input wire logic [4:0] port0_burst_units,
  input wire logic [3:0] port1_burst_length,
  input wire logic port1_word_select,
  input wire logic ack_seen_irq,
  input wire logic [11:0] out_header_byte_addr,
  input wire logic [11:0] out_header_phys_addr
);
  wire logic sel = sfr_module == 4'h2;
  wire logic wc = sfr_wr && sel && sfr_addr == 8'h0c;
  wire logic wi = sfr_wr && sel && sfr_addr == 8'h0d;
  wire logic wh = sfr_wr && sel && sfr_addr == 8'h0e;
  wire logic rc = sfr_rd && sel && sfr_addr == 8'h0c;
  wire logic [9:0] f = {port1_word_select, port1_burst_length,
    port0_word_select, port0_burst_length};
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // enable as last written by firmware
  logic en_m;
  always @(posedge core_clk or posedge reset) begin
    if (reset) en_m <= 1'b0;
    else if (wi) en_m <= sfr_wdata[8];
  end
  // enabled, then ack: request one cycle later
  sequence s_arm; en_m && ack_symbol_seen && !wi; endsequence
  property p_en; port0_burst_enable == (port0_burst_length != 4'h0);
  endproperty
  property p_units; port0_burst_units == port0_burst_length + 5'h1;
  endproperty
  property p_ctl; wc |=> f == $past(sfr_wdata[9:0]); endproperty
  property p_rd; rc |=> sfr_rdata[9:0] == $past(f) &&
    sfr_rdata[13:10] == 4'h0 && !sfr_rdata[15]; endproperty
  property p_idle; !(sfr_rd && sel) |=> sfr_rdata == 16'h0000; endproperty
  property p_hdr; wh |=> out_header_byte_addr == $past(sfr_wdata[11:0]);
  endproperty
  property p_phys; out_header_phys_addr == out_header_byte_addr + PHYS_BASE;
  endproperty
  property p_ack; s_arm |=> ack_seen_irq; endproperty
  property p_hold; ack_seen_irq && !wi |=> ack_seen_irq; endproperty
  property p_clr; wi && !sfr_wdata[0] && !ack_symbol_seen |=> !ack_seen_irq;
  endproperty
  a_en: assert property (p_en) else $error("burst enable off");
  a_units: assert property (p_units) else $error("units off");
  a_ctl: assert property (p_ctl) else $error("control field off");
  a_rd: assert property (p_rd) else $error("control readback off");
  a_idle: assert property (p_idle) else $error("idle read data");
  a_hdr: assert property (p_hdr) else $error("header addr off");
  a_phys: assert property (p_phys) else $error("phys addr off");
  a_ack: assert property (p_ack) else $error("no request");
  a_hold: assert property (p_hold) else $error("request dropped");
  a_clr: assert property (p_clr) else $error("request stuck");
endmodule // port_regs_monitor
bind modem_buffer_port_config_regs port_regs_monitor #(
  .PHYS_BASE(PHYS_BASE)) mon (.*);
`default_nettype wire

//--- testbench/testbench.sv
/*
 register-level test of the buffer port register bank.
 assumes the design and its bound monitor are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic core_clk = 1'b0, reset = 1'b1, sfr_wr = 1'b0, sfr_rd = 1'b0;
  logic ack_symbol_seen = 1'b0;
  logic [3:0] sfr_module = 4'h2;
  logic [7:0] sfr_addr = 8'h00;
  logic [15:0] sfr_wdata = 16'h0000;
  wire logic [15:0] sfr_rdata;
  wire logic [3:0] port0_burst_length, port1_burst_length;
  wire logic port0_word_select, port0_burst_enable, port1_word_select;
  wire logic port1_burst_enable, ack_seen_irq;
  wire logic [4:0] port0_burst_units, port1_burst_units;
  wire logic [11:0] out_header_byte_addr, out_header_phys_addr;
  int err_total = 0, n_checks = 0;
  // nonzero base so translation is visible
  modem_buffer_port_config_regs #(.PHYS_BASE(12'h100)) uut (.*);
  initial begin
    forever #12.5 core_clk = ~core_clk;
  end
  task final_report;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [15:0] s, input logic [15:0] e);
    n_checks++;
    if (s !== e) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge core_clk);
    sfr_wr <= 1'b0;
    #1;
  endtask
  task rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge core_clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge core_clk);
    sfr_rd <= 1'b0;
    #1 chk(sfr_rdata, e);
  endtask
  task ak;
    @(posedge core_clk);
    ack_symbol_seen <= 1'b1;
    @(posedge core_clk);
    ack_symbol_seen <= 1'b0;
    #1;
  endtask
  initial begin
    repeat (2000) @(posedge core_clk);
    err_total++;
    final_report;
  end
  initial begin
    repeat (20) @(posedge core_clk);
    reset <= 1'b0;
    rd(8'h0c, 16'h4070);
    rd(8'h0d, 16'h0000);
    rd(8'h0e, 16'h0000);
    chk({port1_burst_enable, port1_burst_units}, 16'h24);
    chk({port0_burst_enable, port0_burst_units}, 16'h01);
    wr(8'h0c, 16'h0015);
    chk({port0_burst_enable, port0_burst_units}, 16'h26);
    chk({port1_word_select, port1_burst_enable, port0_word_select}, 16'h1);
    wr(8'h0c, 16'hfdff);
    rd(8'h0c, 16'h01ff);
    chk({port1_word_select, port1_burst_units}, 16'h10);
    wr(8'h0d, 16'hffff);
    rd(8'h0d, 16'h0100);
    ak;
    chk(ack_seen_irq, 16'h1);
    rd(8'h0d, 16'h0101);
    wr(8'h0d, 16'h0100);
    chk(ack_seen_irq, 16'h0);
    wr(8'h0d, 16'h0000);
    ak;
    chk(ack_seen_irq, 16'h0);
    rd(8'h0d, 16'h0001);
    @(posedge core_clk);
    ack_symbol_seen <= 1'b1;
    wr(8'h0d, 16'h0100);
    @(posedge core_clk);
    ack_symbol_seen <= 1'b0;
    rd(8'h0d, 16'h0101);
    chk(ack_seen_irq, 16'h1);
    wr(8'h0e, 16'hffff);
    rd(8'h0e, 16'h0fff);
    chk(out_header_phys_addr, 16'h00ff);
    @(posedge core_clk);
    sfr_module <= 4'h3;
    wr(8'h0e, 16'h0000);
    rd(8'h0e, 16'h0000);
    @(posedge core_clk);
    sfr_module <= 4'h2;
    rd(8'h0e, 16'h0fff);
    @(posedge core_clk);
    reset <= 1'b1;
    @(posedge core_clk);
    reset <= 1'b0;
    rd(8'h0c, 16'h4070);
    rd(8'h0d, 16'h0000);
    final_report;
  end
endmodule // testbench
`default_nettype wire
